/* File: hdl/trip_mask_params.svh */
// Purpose: Constants for the trip mask logic.
// Assumes: 25 MHz clock, 24-bit element status word.
// Notes: Register offsets index 32-bit words on the plain port.
`ifndef TRIP_MASK_PARAMS_SVH
`define TRIP_MASK_PARAMS_SVH
`define STATUS_W 24
`define ADDR_W 4
`define REG_UNCOND 4'h0
`define REG_PERM 4'h1
`define REG_BLOCK 4'h2
`define REG_BKOPEN 4'h3
`define REG_CTRL 4'h4
`define REG_STATUS 4'h5
`define REG_WORD 4'h6
`define MASK_RST 24'h000000
`define CTRL_REMOTE_EN_BIT 0
// Bit positions in the status word: row 2 is bits 15..8
`define DIRECT_TRIP_BIT 9
`define REMOTE_OPEN_BIT 8
`define BK_OPEN_BIT 6
// Breaker-open delay in microseconds and its cycle count
`define BK_OPEN_DELAY_US 30
`define CLK_MHZ 25
`define BK_OPEN_CYCLES (`BK_OPEN_DELAY_US * `CLK_MHZ)
`define STATUS_RD_W 5
`endif

/* File: hdl/trip_mask_pkg.sv */
// Purpose: Types for the trip mask logic.
// Assumes: Constants come from the params header.
// Notes: Mask struct groups the four trip masks.
`include "trip_mask_params.svh"
package trip_mask_pkg;
  typedef struct packed {
    logic [`STATUS_W-1:0] unconditional_trip_mask;
    logic [`STATUS_W-1:0] permissive_trip_mask;
    logic [`STATUS_W-1:0] block_trip_mask;
    logic [`STATUS_W-1:0] breaker_open_trip_mask;
  } masks_t;
  typedef struct packed {
    logic direct_trip_input;
    logic permissive_input;
    logic block_input;
    logic breaker_aux_contact;
  } pins_t;
endpackage

/* File: hdl/trip_mask_logic.sv */
// Purpose: Trip decision from four qualified element masks.
// Assumes: Element word from same-clock logic; pins are asynchronous.
// Notes: Trip output is registered, one cycle after its cause.
//
// How it works
// [RQ1] Unconditional mask bits trip without qualification
// [RQ2] Permissive mask trips with permissive or remote-open
// [RQ3] Block mask trips only while block deasserted
// [RQ4] Breaker-open mask trips while timed bit asserted
// [RQ5] Timed bit is delayed inverse of aux contact
// [RQ6] Four paths independent, any one trips
// [RQ7] Three logic inputs; direct trip enters word
// [RQ8] Direct trip bit in unconditional mask forces trip
// [RQ9] Never put timed bit in breaker-open mask
// [RQ10] Avoid non-directional elements in first three masks
// [RQ11] Masks are three rows of eight bits
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "trip_mask_params.svh"
module trip_mask_logic (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [`STATUS_W-1:0] elements_in,
  input wire trip_mask_pkg::pins_t pins_in,
  input wire logic remote_open_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic trip_out,
  output logic timed_breaker_open_out
);
  localparam int unsigned BK_CYC = `BK_OPEN_CYCLES;
  trip_mask_pkg::masks_t masks_q;
  logic remote_en_q;
  trip_mask_pkg::pins_t sync1_q, sync2_q;
  logic [15:0] open_cnt_q;
  logic bk_open_q;
  logic trip_q;
  logic [31:0] rdata_q;
  logic [`STATUS_W-1:0] word;
  logic remote_ok, hit_u, hit_p, hit_b, hit_o, trip_d;
  logic [31:0] rd_mux;

  // ************************************************
  // Input synchronisers
  // ************************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
    end
  end

  // ************************************************
  // Status word assembly
  // ************************************************
  // Direct trip, remote open and timed open bits overlay the word
  always_comb begin
    word = elements_in;
    word[`DIRECT_TRIP_BIT] = sync2_q.direct_trip_input; // RQ7
    word[`REMOTE_OPEN_BIT] = remote_open_in;
    word[`BK_OPEN_BIT] = bk_open_q;
  end

  // ************************************************
  // Breaker open timer
  // ************************************************
  // Counts while aux contact is open, restarts on closure
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      open_cnt_q <= 16'h0000;
      bk_open_q <= 1'b0;
    end else if (sync2_q.breaker_aux_contact) begin
      open_cnt_q <= 16'h0000; // RQ5
      bk_open_q <= 1'b0;
    end else if (open_cnt_q < 16'(BK_CYC - 1)) begin
      open_cnt_q <= open_cnt_q + 16'h0001;
    end else begin
      bk_open_q <= 1'b1; // RQ5
    end
  end

  // ************************************************
  // Trip decision
  // ************************************************
  assign remote_ok = remote_en_q & word[`REMOTE_OPEN_BIT];
  assign hit_u = |(word & masks_q.unconditional_trip_mask); // RQ1 RQ8
  assign hit_p = |(word & masks_q.permissive_trip_mask)
    & (sync2_q.permissive_input | remote_ok); // RQ2
  assign hit_b = |(word & masks_q.block_trip_mask)
    & ~sync2_q.block_input; // RQ3
  assign hit_o = |(word & masks_q.breaker_open_trip_mask)
    & bk_open_q; // RQ4
  assign trip_d = hit_u | hit_p | hit_b | hit_o; // RQ6

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) trip_q <= 1'b0;
    else trip_q <= trip_d;
  end
  assign trip_out = trip_q;
  assign timed_breaker_open_out = bk_open_q;

  // ************************************************
  // Register port
  // ************************************************
  // Masks are three rows of eight, leftmost element in MSB
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      masks_q <= {4{`MASK_RST}};
      remote_en_q <= 1'b0;
    end else if (wr_in) begin
      case (addr_in)
        `REG_UNCOND: masks_q.unconditional_trip_mask <= wdata_in[23:0]; // RQ11
        `REG_PERM: masks_q.permissive_trip_mask <= wdata_in[23:0];
        `REG_BLOCK: masks_q.block_trip_mask <= wdata_in[23:0];
        `REG_BKOPEN: masks_q.breaker_open_trip_mask <= wdata_in[23:0];
        `REG_CTRL: remote_en_q <= wdata_in[`CTRL_REMOTE_EN_BIT];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (addr_in)
      `REG_UNCOND: rd_mux = {8'h00, masks_q.unconditional_trip_mask};
      `REG_PERM: rd_mux = {8'h00, masks_q.permissive_trip_mask};
      `REG_BLOCK: rd_mux = {8'h00, masks_q.block_trip_mask};
      `REG_BKOPEN: rd_mux = {8'h00, masks_q.breaker_open_trip_mask};
      `REG_CTRL: rd_mux = {31'h00000000, remote_en_q};
      `REG_STATUS: rd_mux = {27'h0000000, hit_u, hit_p, hit_b, hit_o,
        trip_q};
      `REG_WORD: rd_mux = {8'h00, word};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) rdata_q <= 32'h00000000;
    else if (rd_in) rdata_q <= rd_mux;
    else rdata_q <= 32'h00000000;
  end
  assign rdata_out = rdata_q;

  // ************************************************
  // Checks
  // ************************************************
  property p_uncond;
    @(posedge clk_in) disable iff (!rstn_in)
      hit_u |=> trip_out;
  endproperty
  a_uncond: assert property (p_uncond) else $error("uncond no trip"); // RQ1

  property p_perm;
    @(posedge clk_in) disable iff (!rstn_in)
      (|(word & masks_q.permissive_trip_mask) && sync2_q.permissive_input)
        |=> trip_out;
  endproperty
  a_perm: assert property (p_perm) else $error("permissive no trip"); // RQ2

  property p_block;
    @(posedge clk_in) disable iff (!rstn_in)
      (sync2_q.block_input && !hit_u && !hit_p && !hit_o) |=> !trip_out;
  endproperty
  a_block: assert property (p_block) else $error("block not obeyed"); // RQ3

  property p_bkopen;
    @(posedge clk_in) disable iff (!rstn_in)
      (|(word & masks_q.breaker_open_trip_mask) && bk_open_q) |=> trip_out;
  endproperty
  a_bkopen: assert property (p_bkopen) else $error("open path no trip"); // RQ4

  property p_timer;
    @(posedge clk_in) disable iff (!rstn_in)
      sync2_q.breaker_aux_contact |=> !bk_open_q;
  endproperty
  a_timer: assert property (p_timer) else $error("open bit early"); // RQ5

  property p_none;
    @(posedge clk_in) disable iff (!rstn_in)
      !trip_d |=> !trip_out;
  endproperty
  a_none: assert property (p_none) else $error("spurious trip"); // RQ6

  property p_direct;
    @(posedge clk_in) disable iff (!rstn_in)
      $rose(sync2_q.direct_trip_input)
        && masks_q.unconditional_trip_mask[`DIRECT_TRIP_BIT] |=> trip_out;
  endproperty
  a_direct: assert property (p_direct) else $error("direct no trip"); // RQ8

  property p_word;
    @(posedge clk_in) disable iff (!rstn_in)
      word[`DIRECT_TRIP_BIT] == sync2_q.direct_trip_input;
  endproperty
  a_word: assert property (p_word) else $error("word bit wrong"); // RQ7

  property p_rd;
    @(posedge clk_in) disable iff (!rstn_in)
      (rd_in && addr_in == `REG_CTRL) |=> rdata_out[0] == $past(remote_en_q);
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong"); // RQ11

  property p_remote;
    @(posedge clk_in) disable iff (!rstn_in)
      (|(word & masks_q.permissive_trip_mask) && remote_ok) |=> trip_out;
  endproperty
  a_remote: assert property (p_remote) else $error("remote no trip"); // RQ2

  property p_open_set;
    @(posedge clk_in) disable iff (!rstn_in)
      (open_cnt_q == 16'(BK_CYC - 1) && !sync2_q.breaker_aux_contact)
        |=> bk_open_q;
  endproperty
  a_open_set: assert property (p_open_set) else $error("open late"); // RQ5

  c_uncond: cover property (@(posedge clk_in) hit_u ##1 trip_out);
  c_perm: cover property (@(posedge clk_in) hit_p ##1 trip_out);
  c_bkopen: cover property (@(posedge clk_in) $rose(bk_open_q));
  c_block: cover property (@(posedge clk_in) hit_b ##1 trip_out);
endmodule
`default_nettype wire

/* File: verification/breaker_comms_model.sv */
// Purpose: Far side: comms equipment levels and a breaker.
// Assumes: Trip coil opens the breaker, close request recloses it.
// Notes: Aux contact is high while the breaker is closed.
`timescale 1ns/1ns
`default_nettype none
module breaker_comms_model (
  input wire logic clk_in,
  input wire logic trip_in,
  input wire logic close_in,
  input wire logic [2:0] comms_in,
  output var trip_mask_pkg::pins_t pins_out
);
  logic open_q = 1'b0;
  // Breaker opens on trip, recloses only on request
  always @(posedge clk_in) begin
    if (close_in)
      open_q <= 1'b0;
    else if (trip_in)
      open_q <= 1'b1;
  end
  // Direct, permissive, block levels; aux follows breaker
  assign pins_out = {comms_in, ~open_q};
endmodule
`default_nettype wire

/* File: verification/trip_mask_logic_tb_top.sv */
// Purpose: Random and corner checks of the trip decision.
// Assumes: Breaker held closed during the random phase.
// Notes: Mask bits 8 and 6 always, 11 and 10 in masks 0-2, kept clear.
`timescale 1ns/1ns
`default_nettype none
module trip_mask_logic_tb_top;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [23:0] elements_in = 24'h000000;
  logic remote_open_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic close = 1'b1;
  logic ren = 1'b0;
  logic [2:0] comms = 3'h0;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h00000000;
  logic [31:0] rdata_out;
  logic trip_out;
  logic timed_out;
  trip_mask_pkg::pins_t pins;
  logic [23:0] m [4];
  int errors = 0;
  int num_checks = 0;
  int seed = 27690;
  always #20 clk_in = ~clk_in;
  trip_mask_logic dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .elements_in(elements_in), .pins_in(pins),
    .remote_open_in(remote_open_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .trip_out(trip_out),
    .timed_breaker_open_out(timed_out));
  breaker_comms_model far (.clk_in(clk_in), .trip_in(trip_out),
    .close_in(close), .comms_in(comms), .pins_out(pins));
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    check("rdata", rdata_out, e);
  endtask
  // Expected status word: direct, remote and timed bits overlaid
  function automatic logic [23:0] exp_word(input logic bk);
    return {elements_in[23:10], comms[2], remote_open_in, elements_in[7],
      bk, elements_in[5:0]};
  endfunction
  // Expected path hits {uncond, perm, block, open}, trip in bit 0
  function automatic logic [4:0] exp_status(input logic bk);
    logic [23:0] w;
    logic [3:0] h;
    w = exp_word(bk);
    h[3] = |(w & m[0]);
    h[2] = |(w & m[1]) & (comms[1] | ren & remote_open_in);
    h[1] = |(w & m[2]) & ~comms[0];
    h[0] = |(w & m[3]) & bk;
    return {h, |h};
  endfunction
  // Expected trip from the four qualified paths
  function automatic logic exp_trip(input logic bk);
    logic [4:0] s;
    s = exp_status(bk);
    return s[0];
  endfunction
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(4'h0, 32'h00000000);
    rd(4'hF, 32'h00000000);
    for (int i = 0; i < 200; i++) begin
      for (int k = 0; k < 4; k++) begin
        m[k] = 24'($random(seed) & $random(seed))
          & (k < 3 ? 24'hFFF2BF : 24'hFFFEBF);
        wr(k[3:0], {8'h00, m[k]});
      end
      ren = 1'($random(seed));
      wr(4'h4, {31'h00000000, ren});
      rd(i[3:0] & 4'h3, {8'h00, m[i % 4]});
      rd(4'h4, {31'h00000000, ren});
      @(posedge clk_in);
      elements_in <= 24'($random(seed) & $random(seed));
      {remote_open_in, comms} <= 4'($random(seed));
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      check("trip", trip_out, exp_trip(1'b0));
      rd(4'h5, {27'h0000000, exp_status(1'b0)});
      rd(4'h6, {8'h00, exp_word(1'b0)});
    end
    // Direct trip opens the breaker, then the breaker-open path
    m = '{24'h000200, 24'h000000, 24'h000000, 24'h800000};
    for (int k = 0; k < 4; k++)
      wr(k[3:0], {8'h00, m[k]});
    elements_in <= 24'h000000;
    comms <= 3'h4;
    close <= 1'b0;
    repeat (6) @(posedge clk_in);
    check("trip", trip_out, 32'h00000001);
    comms <= 3'h0;
    repeat (740) @(posedge clk_in);
    check("timed", timed_out, 32'h00000000);
    repeat (20) @(posedge clk_in);
    check("timed", timed_out, 32'h00000001);
    elements_in <= 24'h800000;
    repeat (3) @(posedge clk_in);
    check("trip", trip_out, 32'h00000001);
    close <= 1'b1;
    repeat (6) @(posedge clk_in);
    check("trip", trip_out, 32'h00000000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
